// ### scan_switch_defs.svh
// Constants for the addressable scan path switch
`ifndef SCAN_SWITCH_DEFS_SVH
`define SCAN_SWITCH_DEFS_SVH

`define PORT_COUNT      3
`define PAD_MAX         4
`define ADDR_BITS       10
`define POS_BITS        3
`define CFG_BITS        3
`define CNT_BITS        4
`define BYP_MODE_BIT    5
`define BYP_SRC_BIT     4
`define BYP_DRV_BIT     3
`define FIFO_DEPTH      16
`define ACK_BITS        2'h3
`define ACK_PATTERN     4'hC
`define PIN_RESET       27'h7FFFFFF

`endif

// ### scan_switch_pkg.sv
// Types shared by the addressable scan path switch
package scan_switch_pkg;
`include "scan_switch_defs.svh"

    typedef enum logic [1:0] {
        SYM_ONE,
        SYM_ZERO,
        SYM_SEL,
        SYM_IDLE
    } sym_t;

    typedef enum logic [2:0] {
        P_START,
        P_ADDR,
        P_POS,
        P_CFG,
        P_END,
        P_FAIL
    } parse_t;

    typedef struct packed {
        logic                   test_clk;
        logic                   primary_in;
        logic                   cascade_in;
        logic [`PORT_COUNT-1:0] port_return;
        logic [5:0]             bypass_n;
        logic [`ADDR_BITS-1:0]  address;
        logic [`POS_BITS-1:0]   position;
        logic                   from_cascade;
        logic                   to_cascade;
    } pins_t;

    typedef struct packed {
        pins_t                  s1;
        pins_t                  s2;
        pins_t                  s3;
        pins_t                  stable;
        logic [`PAD_MAX-1:0]    pad;
        logic [`PORT_COUNT-1:0] port_out;
        logic [`PORT_COUNT-1:0] active_out;
        logic [2:0]             pad_count;
        logic                   pri_out;
        logic                   pri_oe;
        logic                   cas_out;
        logic                   cas_oe;
        logic                   in_frame;
        logic                   pair_half;
        logic                   first_bit;
        parse_t                 pstate;
        logic [`ADDR_BITS-1:0]  sh;
        logic [`CNT_BITS-1:0]   cnt;
        logic                   addr_ok;
        logic [`POS_BITS-1:0]   pos_rx;
        logic                   hit;
        logic [`CFG_BITS-1:0]   cfg_new;
        logic [`CFG_BITS-1:0]   cfg;
        logic                   cfg_valid;
        logic                   ack_busy;
        logic [1:0]             ack_cnt;
    } core_t;
endpackage

// ### addressable_scan_path_switch.sv
// Scan path switch: pin sync, select decoder, symbol FIFO and pad-bit routing
//
// Behaviour
// R1 - Eight port configurations, one per active/inactive mix of three ports.
// R2 - Active ports chained 0,1,2; pad before first and after each port.
// R3 - Path holds active count plus one pads; none when idle, except middle.
// R4 - Middle device with no port active passes cascade through one pad.
// R5 - Position sets endpoints: first, last, middle and single device paths.
// R6 - Bypass mode while bypass-mode pin is low.
// R7 - Bypass mode ignores select sequences; pins alone configure.
// R8 - Three low bypass pins control the three secondary ports.
// R9 - A port is active when its bypass pin is low.
// R10 - Bypass pins 4 and 3 choose input source and output drive pin.
// R11 - Pin 4 high picks cascade input; pin 3 high picks cascade output.
// R12 - Board holds both source and drive pins low for a lone device.
// R13 - Master broadcasts bit-pair select stream; non-bypass devices decode it.
// R14 - Pairs: HH idle, LL select, LH one, HL zero.
// R15 - Select carries 10-bit address and 3-bit position, compared with pins.
// R16 - On address and position match, load configuration bits that follow.
// R17 - Successful select sends acknowledge on scan output immediately.
// R18 - Only the last device acknowledges, after connections are made.
// R19 - Failed select gives no response.
// R20 - Select accepted while the access port sits in a pause state.
// R21 - Pad bits capture on every test clock, pause states included.
// R22 - Master should gate the test clock when shifting may pause.
// R23 - Test program counts pad bits in vector lengths.
// R24 - After reset no port is active and no path is routed.
`timescale 1ns/1ps
`include "scan_switch_defs.svh"

module sym_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 count;
    } fifo_t;
    fifo_t st;
    fifo_t next_st;
    logic  push;
    logic  pop;

    assign in_ready  = st.count != (AW+1)'(DEPTH);
    assign out_valid = st.count != '0;
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

module addressable_scan_path_switch (
    input  wire logic                   core_clk,
    input  wire logic                   reset_n,
    input  wire logic                   test_clk,
    input  wire logic                   primary_scan_in,
    input  wire logic                   cascade_scan_in,
    input  wire logic [`PORT_COUNT-1:0] secondary_scan_return,
    input  wire logic [5:0]             bypass_select_pins_n,
    input  wire logic [`ADDR_BITS-1:0]  bus_address_pins,
    input  wire logic [`POS_BITS-1:0]   cascade_position_pins,
    input  wire logic                   from_cascade_strap,
    input  wire logic                   to_cascade_strap,
    output logic                        primary_scan_out,
    output logic                        primary_scan_out_oe,
    output logic                        cascade_scan_out,
    output logic                        cascade_scan_out_oe,
    output logic [`PORT_COUNT-1:0]      secondary_scan_out,
    output logic [`PORT_COUNT-1:0]      secondary_active,
    output logic [2:0]                  pad_count
);
    scan_switch_pkg::core_t st;
    scan_switch_pkg::core_t next_st;
    scan_switch_pkg::pins_t raw;
    scan_switch_pkg::sym_t  push_sym;
    logic                   push_valid;
    logic                   push_ready;
    logic [1:0]             pop_data;
    logic                   pop_valid;
    logic                   pop_ready;
    logic                   rise;
    logic                   byp_mode;
    logic [`PORT_COUNT-1:0] eff_active;
    logic                   eff_from;
    logic                   eff_to;
    logic                   routed;
    logic                   src_bit;
    scan_switch_pkg::sym_t  sym;

    assign raw = '{test_clk, primary_scan_in, cascade_scan_in, secondary_scan_return,
                   bypass_select_pins_n, bus_address_pins, cascade_position_pins,
                   from_cascade_strap, to_cascade_strap};

    assign primary_scan_out    = st.pri_out;
    assign primary_scan_out_oe = st.pri_oe;
    assign cascade_scan_out    = st.cas_out;
    assign cascade_scan_out_oe = st.cas_oe;
    assign secondary_scan_out  = st.port_out;
    assign secondary_active    = st.active_out;
    assign pad_count           = st.pad_count;

    // Symbols wait here while an acknowledge is on the wire
    sym_fifo #(.WIDTH(2), .DEPTH(`FIFO_DEPTH)) u_sym_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_data   (push_sym),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (pop_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready)
    );

    assign sym       = scan_switch_pkg::sym_t'(pop_data);
    assign pop_ready = !st.ack_busy;

    always_comb begin
        int k;
        k = 0;
        next_st = st;
        push_valid = 1'b0;
        push_sym   = scan_switch_pkg::SYM_IDLE;
        // A bit counts once the second and third stages agree
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.stable = (st.s2 & ~(st.s2 ^ st.s3)) | (st.stable & (st.s2 ^ st.s3));
        rise = next_st.stable.test_clk && !st.stable.test_clk;

        byp_mode = !st.stable.bypass_n[`BYP_MODE_BIT]; // R6
        if (byp_mode) begin
            eff_active = ~st.stable.bypass_n[`PORT_COUNT-1:0]; // R8 R9
            eff_from   = st.stable.bypass_n[`BYP_SRC_BIT];     // R10 R11
            eff_to     = st.stable.bypass_n[`BYP_DRV_BIT];     // R10 R11
            routed     = |eff_active || (eff_from && eff_to);
        end else begin
            eff_active = st.cfg_valid ? st.cfg : '0; // R24
            eff_from   = st.stable.from_cascade;
            eff_to     = st.stable.to_cascade;
            routed     = st.cfg_valid && (|eff_active || (eff_from && eff_to)); // R24
        end
        src_bit = eff_from ? st.stable.cascade_in : st.stable.primary_in; // R5

        // Pads shift on every rising test clock edge while a path is routed, paused or not
        if (rise && routed) begin
            next_st.pad[0] = src_bit; // R2 R21
        end
        for (int i = 0; i < `PORT_COUNT; i++) begin
            next_st.port_out[i] = 1'b1;
            if (eff_active[i]) begin
                next_st.port_out[i] = st.pad[k]; // R1 R2
                k = k + 1;
                if (rise) begin
                    next_st.pad[k] = st.stable.port_return[i]; // R21
                end
            end
        end
        next_st.active_out = eff_active;
        next_st.pad_count  = routed ? 3'(k + 1) : 3'h0; // R3 R4
        next_st.cas_out    = st.pad[k];
        next_st.cas_oe     = routed && eff_to; // R4 R5
        next_st.pri_oe     = (routed && !eff_to) || st.ack_busy; // R5
        next_st.pri_out    = st.ack_busy ? 1'(`ACK_PATTERN >> st.ack_cnt) : st.pad[k];

        // Bit-pair decode of the primary input, skipped in bypass mode
        if (byp_mode) begin
            next_st.in_frame  = 1'b0; // R7
            next_st.pair_half = 1'b0;
            next_st.pstate    = scan_switch_pkg::P_START;
        end else if (rise) begin // R13 R20
            if (!st.in_frame && !st.stable.primary_in) begin
                next_st.in_frame  = 1'b1;
                next_st.pair_half = 1'b1;
                next_st.first_bit = 1'b0;
            end else if (st.in_frame && !st.pair_half) begin
                next_st.pair_half = 1'b1;
                next_st.first_bit = st.stable.primary_in;
            end else if (st.in_frame) begin
                next_st.pair_half = 1'b0;
                push_valid = 1'b1;
                case ({st.first_bit, st.stable.primary_in}) // R14
                    2'b00:   push_sym = scan_switch_pkg::SYM_SEL;
                    2'b01:   push_sym = scan_switch_pkg::SYM_ONE;
                    2'b10:   push_sym = scan_switch_pkg::SYM_ZERO;
                    default: push_sym = scan_switch_pkg::SYM_IDLE;
                endcase
                if (push_sym == scan_switch_pkg::SYM_IDLE) begin
                    next_st.in_frame = 1'b0;
                end
            end
        end
        // A lost symbol would corrupt the frame, so overflow forces a silent abort
        if (push_valid && !push_ready && !byp_mode) begin
            next_st.pstate = scan_switch_pkg::P_FAIL; // R19
        end else if (pop_valid && pop_ready && !byp_mode) begin
            case (st.pstate)
                scan_switch_pkg::P_START: begin
                    next_st.cnt     = '0;
                    next_st.hit     = 1'b0;
                    next_st.pstate  = (sym == scan_switch_pkg::SYM_SEL) ?
                                      scan_switch_pkg::P_ADDR : scan_switch_pkg::P_FAIL;
                end
                scan_switch_pkg::P_ADDR, scan_switch_pkg::P_POS, scan_switch_pkg::P_CFG: begin
                    if (sym == scan_switch_pkg::SYM_SEL && st.pstate == scan_switch_pkg::P_POS
                        && st.cnt == '0) begin
                        next_st.pstate = scan_switch_pkg::P_END;
                    end else if (sym == scan_switch_pkg::SYM_SEL) begin
                        next_st.pstate = scan_switch_pkg::P_FAIL;
                    end else if (sym == scan_switch_pkg::SYM_IDLE) begin
                        next_st.pstate = scan_switch_pkg::P_START; // R19
                    end else begin
                        next_st.sh  = {st.sh[`ADDR_BITS-2:0], sym == scan_switch_pkg::SYM_ONE};
                        next_st.cnt = st.cnt + 1'b1;
                        if (st.pstate == scan_switch_pkg::P_ADDR
                            && st.cnt == `CNT_BITS'(`ADDR_BITS - 1)) begin
                            next_st.addr_ok = next_st.sh == st.stable.address; // R15
                            next_st.cnt     = '0;
                            next_st.pstate  = scan_switch_pkg::P_POS;
                        end else if (st.pstate == scan_switch_pkg::P_POS
                                     && st.cnt == `CNT_BITS'(`POS_BITS - 1)) begin
                            next_st.pos_rx = next_st.sh[`POS_BITS-1:0];
                            next_st.cnt    = '0;
                            next_st.pstate = scan_switch_pkg::P_CFG;
                        end else if (st.pstate == scan_switch_pkg::P_CFG
                                     && st.cnt == `CNT_BITS'(`CFG_BITS - 1)) begin
                            if (st.addr_ok && st.pos_rx == st.stable.position) begin
                                next_st.hit     = 1'b1; // R15 R16
                                next_st.cfg_new = next_st.sh[`CFG_BITS-1:0];
                            end
                            next_st.cnt    = '0;
                            next_st.pstate = scan_switch_pkg::P_POS;
                        end
                    end
                end
                scan_switch_pkg::P_END: begin
                    next_st.pstate = scan_switch_pkg::P_START;
                    if (sym == scan_switch_pkg::SYM_IDLE && st.hit) begin
                        next_st.cfg       = st.cfg_new; // R16
                        next_st.cfg_valid = 1'b1;
                        next_st.ack_busy  = !st.stable.to_cascade; // R17 R18
                        next_st.ack_cnt   = '0;
                    end
                end
                scan_switch_pkg::P_FAIL: begin
                    if (sym == scan_switch_pkg::SYM_IDLE) begin
                        next_st.pstate = scan_switch_pkg::P_START; // R19
                    end
                end
                default: next_st.pstate = scan_switch_pkg::P_START;
            endcase
        end
        if (st.ack_busy && rise) begin
            next_st.ack_cnt = st.ack_cnt + 1'b1; // R17
            if (st.ack_cnt == `ACK_BITS) begin
                next_st.ack_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st        <= '0;
            st.s1     <= `PIN_RESET;
            st.s2     <= `PIN_RESET;
            st.s3     <= `PIN_RESET;
            st.stable <= `PIN_RESET;
            st.pstate <= scan_switch_pkg::P_START;
        end else begin
            st <= next_st;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence seq_ack_start;
        $rose(st.ack_busy);
    endsequence
    sequence seq_ack_hold;
        st.ack_busy [*3];
    endsequence

    chk_reset_no_route: assert property (!byp_mode && !st.cfg_valid |=> !st.cas_oe) // R24
        else $error("cascade output driven before any configuration");
    chk_bypass_ports: assert property (byp_mode ##1 byp_mode |=> // R8
        st.active_out == ~$past(st.stable.bypass_n[2:0]))
        else $error("bypass pins do not steer secondary ports");
    chk_ignore_select: assert property (byp_mode |-> !push_valid) // R7
        else $error("select stream decoded in bypass mode");
    chk_pad_shift: assert property (rise && routed |=> st.pad[0] == $past(src_bit)) // R21
        else $error("first pad did not capture on test clock edge");
    chk_middle_pass: assert property (routed && eff_from && eff_to && eff_active == '0 // R4
        |=> st.cas_oe && st.pad_count == 3'h1)
        else $error("middle device lost its single pad path");
    chk_pad_count: assert property (routed |=> st.pad_count == $past(3'($countones(eff_active)) + 3'h1)) // R3
        else $error("pad count differs from active ports plus one");
    chk_ack_source: assert property (seq_ack_start |-> st.cfg_valid && !st.stable.to_cascade) // R18
        else $error("acknowledge without a completed select");
    chk_ack_drive: assert property (seq_ack_start |-> seq_ack_hold ##1 st.pri_oe) // R17
        else $error("acknowledge not driven on primary output");
    chk_silent_fail: assert property (st.pstate == scan_switch_pkg::P_FAIL |=> !$rose(st.ack_busy)) // R19
        else $error("response sent for failed select");
endmodule

// ### scan_master_model.sv
// Behavioural test-bus master: gated test clock, bit-pair select frames, data shifting
`timescale 1ns/1ps

module scan_master_model (
    output logic      test_clk,
    output logic      scan_data,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic [11:0] ack_oe;
    logic [11:0] ack_out;

    // Gated clock: it rests low between frames and during pauses
    initial begin
        test_clk = 1'b0;
        scan_data = 1'b1;
        ack_oe = 12'h000;
        ack_out = 12'h000;
    end

    // Data moves while the clock is low; the reply is taken just before the rising edge
    task automatic tick(input logic b, output logic o, output logic oe);
        scan_data = b;
        #80;
        o = tdo;
        oe = tdo_oe;
        test_clk = 1'b1;
        #80;
        test_clk = 1'b0;
    endtask

    task automatic pair(input logic a, input logic b);
        logic o;
        logic oe;
        tick(a, o, oe);
        tick(b, o, oe);
    endtask

    task automatic data_bit(input logic b);
        if (b) begin
            pair(1'b0, 1'b1);
        end else begin
            pair(1'b1, 1'b0);
        end
    endtask

    // A pause leaves the clock stopped between the position and config fields
    task automatic frame(input logic [9:0] addr, input logic [2:0] pos,
                         input logic [2:0] cfg, input int pause_ns);
        pair(1'b1, 1'b1);
        pair(1'b0, 1'b0);
        for (int i = 9; i >= 0; i--) begin
            data_bit(addr[i]);
        end
        for (int i = 2; i >= 0; i--) begin
            data_bit(pos[i]);
        end
        #(pause_ns);
        for (int i = 2; i >= 0; i--) begin
            data_bit(cfg[i]);
        end
        pair(1'b0, 1'b0);
        pair(1'b1, 1'b1);
        for (int i = 0; i < 12; i++) begin
            tick(1'b1, ack_out[i], ack_oe[i]);
        end
    endtask
endmodule

// ### tb.sv
// Self-checking bench for the addressable scan path switch
`timescale 1ns/1ps

module tb;
    localparam logic [9:0] OWN_ADDR = 10'h065;
    localparam logic [2:0] OWN_POS  = 3'h1;

    logic       core_clk;
    logic       reset_n;
    logic       test_clk;
    logic       primary_scan_in;
    logic       cascade_scan_in;
    logic [2:0] secondary_scan_out;
    logic [5:0] bypass_select_pins_n;
    logic [9:0] bus_address_pins;
    logic [2:0] cascade_position_pins;
    logic       from_cascade_strap;
    logic       to_cascade_strap;
    logic       primary_scan_out;
    logic       primary_scan_out_oe;
    logic       cascade_scan_out;
    logic       cascade_scan_out_oe;
    logic [2:0] secondary_active;
    logic [2:0] pad_count;
    int         fail_count;
    int         checks;

    // Each secondary chain is a bare wire, so data returns as sent
    addressable_scan_path_switch DUT (
        .core_clk              (core_clk),
        .reset_n               (reset_n),
        .test_clk              (test_clk),
        .primary_scan_in       (primary_scan_in),
        .cascade_scan_in       (cascade_scan_in),
        .secondary_scan_return (secondary_scan_out),
        .bypass_select_pins_n  (bypass_select_pins_n),
        .bus_address_pins      (bus_address_pins),
        .cascade_position_pins (cascade_position_pins),
        .from_cascade_strap    (from_cascade_strap),
        .to_cascade_strap      (to_cascade_strap),
        .primary_scan_out      (primary_scan_out),
        .primary_scan_out_oe   (primary_scan_out_oe),
        .cascade_scan_out      (cascade_scan_out),
        .cascade_scan_out_oe   (cascade_scan_out_oe),
        .secondary_scan_out    (secondary_scan_out),
        .secondary_active      (secondary_active),
        .pad_count             (pad_count)
    );

    scan_master_model master (
        .test_clk  (test_clk),
        .scan_data (primary_scan_in),
        .tdo       (primary_scan_out),
        .tdo_oe    (primary_scan_out_oe)
    );

    always #5 core_clk = ~core_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    // Pins pass a synchroniser first, so give them ten core cycles to land
    task automatic settle();
        repeat (10) @(posedge core_clk);
        #1;
    endtask

    // First four samples with the drive enable high, first one in bit 0
    task automatic get_ack(output int n, output logic [3:0] bits);
        n = 0;
        bits = 4'h0;
        for (int i = 0; i < 12; i++) begin
            if (master.ack_oe[i] === 1'b1) begin
                if (n < 4) begin
                    bits[n] = master.ack_out[i];
                end
                n++;
            end
        end
    endtask

    task automatic expect_path(input logic [2:0] act, input logic [2:0] pads,
                               input logic pri, input logic cas);
        check(secondary_active, act, "active ports");
        check(pad_count, pads, "pad count");
        check(primary_scan_out_oe, pri, "primary drive");
        check(cascade_scan_out_oe, cas, "cascade drive");
    endtask

    task automatic t_reset();
        expect_path(3'h0, 3'h0, 1'b0, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_bad_frames();
        int         n;
        logic [3:0] bits;
        master.frame(OWN_ADDR ^ 10'h200, OWN_POS, 3'h7, 0);
        get_ack(n, bits);
        check(8'(n), 8'h00, "reply to foreign address");
        master.frame(OWN_ADDR, OWN_POS ^ 3'h4, 3'h7, 0);
        get_ack(n, bits);
        check(8'(n), 8'h00, "reply to foreign position");
        settle();
        expect_path(3'h0, 3'h0, 1'b0, 1'b0);
        $display("test bad frames done");
    endtask

    task automatic t_good_single();
        int         n;
        logic [3:0] bits;
        master.frame(OWN_ADDR, OWN_POS, 3'h5, 0);
        get_ack(n, bits);
        check(bits, 4'hC, "acknowledge pattern");
        settle();
        expect_path(3'h5, 3'h3, 1'b1, 1'b0);
        $display("test good single done");
    endtask

    task automatic t_first_paused();
        int         n;
        logic [3:0] bits;
        to_cascade_strap = 1'b1;
        settle();
        master.frame(OWN_ADDR, OWN_POS, 3'h3, 2000);
        get_ack(n, bits);
        check(8'(n), 8'h00, "reply from non-last device");
        settle();
        expect_path(3'h3, 3'h3, 1'b0, 1'b1);
        from_cascade_strap = 1'b1;
        settle();
        master.frame(OWN_ADDR, OWN_POS, 3'h0, 0);
        get_ack(n, bits);
        check(8'(n), 8'h00, "reply from middle device");
        settle();
        expect_path(3'h0, 3'h1, 1'b0, 1'b1);
        from_cascade_strap = 1'b0;
        to_cascade_strap = 1'b0;
        $display("test first paused done");
    endtask

    task automatic t_bypass_ignores();
        int         n;
        logic [3:0] bits;
        bypass_select_pins_n = 6'h07;
        settle();
        master.frame(OWN_ADDR, OWN_POS, 3'h7, 0);
        get_ack(n, bits);
        check(8'(n), 8'h00, "reply in bypass mode");
        settle();
        expect_path(3'h0, 3'h0, 1'b0, 1'b0);
        $display("test bypass ignores done");
    endtask

    task automatic t_bypass_table();
        logic [2:0] act;
        int         pads;
        for (int b = 0; b < 32; b++) begin
            bypass_select_pins_n = {1'b0, 5'(b)};
            settle();
            act = ~3'(b);
            pads = ($countones(act) != 0) ? $countones(act) + 1 : ((b[4] && b[3]) ? 1 : 0);
            check(secondary_active, act, "bypass ports");
            check(pad_count, 8'(pads), "bypass pads");
            check(primary_scan_out_oe, (pads != 0) && !b[3], "bypass primary");
            check(cascade_scan_out_oe, (pads != 0) && b[3], "bypass cascade");
        end
        $display("test bypass table done");
    endtask

    // Ports 0 and 2: three pads, so a bit is seen three clocks after it goes in
    task automatic t_routing();
        logic [15:0] pat;
        logic        o[16];
        logic        c[16];
        logic        oe;
        pat = 16'hB2D4;
        // First pass drives the primary pin, second the cascade pin
        for (int m = 0; m < 2; m++) begin
            bypass_select_pins_n = (m == 0) ? 6'h02 : 6'h0A;
            settle();
            for (int j = 0; j < 16; j++) begin
                master.tick(pat[j], o[j], oe);
                c[j] = cascade_scan_out;
            end
            for (int j = 3; j < 16; j++) begin
                check((m == 0) ? o[j] : c[j-1], pat[j-3], "routed bit");
            end
        end
        $display("test routing done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        cascade_scan_in = 1'b0;
        bypass_select_pins_n = 6'h3F;
        bus_address_pins = OWN_ADDR;
        cascade_position_pins = OWN_POS;
        from_cascade_strap = 1'b0;
        to_cascade_strap = 1'b0;
        fail_count = 0;
        checks = 0;
        repeat (4) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        settle();
        t_reset();
        t_bad_frames();
        t_good_single();
        t_first_paused();
        t_bypass_ignores();
        t_bypass_table();
        t_routing();
        give_verdict();
    end

    initial begin
        #500000;
        fail_count++;
        $display("wrong value at %0t: run did not finish in time", $time);
        give_verdict();
    end
endmodule
